/* File: design/energy_pulse_port.sv */
// energy_pulse_port: digital output port of the meter, pulse or switch use.
// assumes register requests and energy steps come from logic on clk.
// Operation
// - codes 44001, 44008, 44011 pick real, reactive, apparent energy pulses.
// - source code zero: no pulses, port is a software switch.
// - switch value zero drives low, one drives high; one after reset.
// - switch value reaches the port only while the source code is zero.
// - polarity zero idles high, one idles low and inverts the pulse.
// - modbus data scalar sets pulse weight from 0.00001 up to 100.
// - bacnet pulse scalar object sets pulse weight with the same coding.
// - pulses follow accumulated energy steps, not instantaneous readings.
// - indicator led lights during each pulse, dark otherwise.
// - bacnet objects hold switch value, source and polarity, same coding.
`timescale 1ns/100ps
module energy_pulse_port
  import pulse_port_pkg::*;
#(
  parameter int PULSE_CNT = PULSE_CYCLES
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          proto_bacnet,
  input  wire reg_req_t      req,
  input  wire energy_step_t  energy,
  output logic [15:0]        rd_data,
  output logic               rd_valid,
  output logic               port_level,
  output logic               pulse_led
);

  typedef struct packed {
    logic [15:0] sw;
    logic [15:0] src;
    logic [15:0] pol;
    logic [15:0] dscalar;
    logic [15:0] pscalar;
    logic [31:0] acc;
    logic        start;
    logic [15:0] rdata;
    logic        rvalid;
    logic        level;
    logic        led;
  } port_state_t;

  port_state_t s_reg;
  port_state_t s_next;
  logic        t_idle;
  logic        t_active;
  logic [31:0] weight;
  logic [15:0] step;
  logic [32:0] sum;
  logic [31:0] acc_add;
  reg_sel_t    sel;

  // the same address means a register in modbus use, an object in bacnet use
  function automatic reg_sel_t decode(input logic bac, input logic [15:0] a);
    decode = SEL_NONE;
    if (!bac) begin
      if (a == OFS_SWITCH_LEVEL) decode = SEL_SWITCH;
      else if (a == OFS_PULSE_SOURCE) decode = SEL_SOURCE;
      else if (a == OFS_RELAY_POLARITY) decode = SEL_POLARITY;
      else if (a == OFS_DATA_SCALAR) decode = SEL_DSCALAR;
    end else begin
      if (a == OBJ_SWITCH_LEVEL) decode = SEL_SWITCH;
      else if (a == OBJ_PULSE_SOURCE) decode = SEL_SOURCE;
      else if (a == OBJ_RELAY_POLARITY) decode = SEL_POLARITY;
      else if (a == OBJ_PULSE_SCALAR) decode = SEL_PSCALAR;
    end
  endfunction

  // energy step of the chosen source; an unknown code yields nothing
  function automatic logic [15:0] pick_step(input logic [15:0] code,
                                            input energy_step_t e);
    pick_step = 16'h0000;
    if (e.valid) begin
      if (code == SRC_REAL) pick_step = e.active_step;
      else if (code == SRC_REACTIVE) pick_step = e.reactive_step;
      else if (code == SRC_APPARENT) pick_step = e.apparent_step;
    end
  endfunction

  pulse_timer #(
    .WIDTH (CNT_W'(PULSE_CNT))
  ) u_timer (
    .clk    (clk),
    .arst_n (arst_n),
    .start  (s_reg.start),
    .idle   (t_idle),
    .active (t_active)
  );

  // weight follows the scalar of the protocol in use
  assign weight = proto_bacnet ? scalar_weight(s_reg.pscalar)
                               : scalar_weight(s_reg.dscalar);
  assign sel    = decode(proto_bacnet, req.addr);
  assign step   = pick_step(s_reg.src, energy);
  assign sum    = {1'b0, s_reg.acc} + {17'h0_0000, step};
  // saturate rather than wrap when pulses fall far behind the energy
  assign acc_add = sum[32] ? 32'hffff_ffff : sum[31:0];

  // register file, accumulator and port level
  always_comb begin
    s_next        = s_reg;
    s_next.start  = 1'b0;
    s_next.rvalid = req.rd;
    s_next.rdata  = 16'h0000;
    s_next.acc    = acc_add;
    // a start is only issued while the timer is free and no start is in flight
    if (s_reg.src != SRC_SWITCH && t_idle && !s_reg.start
        && s_reg.acc >= weight) begin
      s_next.acc   = acc_add - weight;
      s_next.start = 1'b1;
    end
    if (req.rd) begin
      unique case (sel)
        SEL_SWITCH:   s_next.rdata = s_reg.sw;
        SEL_SOURCE:   s_next.rdata = s_reg.src;
        SEL_POLARITY: s_next.rdata = s_reg.pol;
        SEL_DSCALAR:  s_next.rdata = s_reg.dscalar;
        SEL_PSCALAR:  s_next.rdata = s_reg.pscalar;
        SEL_NONE:     s_next.rdata = 16'h0000;
      endcase
    end
    if (req.wr) begin
      unique case (sel)
        SEL_SWITCH:   s_next.sw = req.wdata;
        SEL_SOURCE: begin
          s_next.src   = req.wdata;
          // a new source starts from an empty remainder
          s_next.acc   = 32'h0000_0000;
          s_next.start = 1'b0;
        end
        SEL_POLARITY: s_next.pol = req.wdata;
        SEL_DSCALAR:  s_next.dscalar = req.wdata;
        SEL_PSCALAR:  s_next.pscalar = req.wdata;
        SEL_NONE:     s_next.sw = s_reg.sw;
      endcase
    end
    // switch use owns the pin only with source zero; else the pulse does
    if (s_reg.src == SRC_SWITCH) begin
      s_next.level = s_reg.sw[LEVEL_BIT];
      s_next.led   = 1'b0;
    end else begin
      s_next.level = t_active ^ ~s_reg.pol[POLARITY_BIT];
      s_next.led   = t_active;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '{sw: RST_SWITCH_LEVEL, src: RST_PULSE_SOURCE,
                 pol: RST_RELAY_POLARITY, dscalar: RST_SCALAR,
                 pscalar: RST_SCALAR, acc: 32'h0000_0000, start: 1'b0,
                 rdata: 16'h0000, rvalid: 1'b0, level: 1'b1, led: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data    = s_reg.rdata;
  assign rd_valid   = s_reg.rvalid;
  assign port_level = s_reg.level;
  assign pulse_led  = s_reg.led;

  // switch value reaches the pin once the source has stood at zero
  a_switch_level: assert property (@(posedge clk) disable iff (!arst_n)
    (s_reg.src == SRC_SWITCH && $stable(s_reg.src) && $stable(s_reg.sw))
    |=> port_level == $past(s_reg.sw[LEVEL_BIT]))
    else $error("switch value not on the port");

  a_switch_no_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    (s_reg.src == SRC_SWITCH) |=> !s_reg.start)
    else $error("pulse started in switch use");

  a_idle_level: assert property (@(posedge clk) disable iff (!arst_n)
    (s_reg.src != SRC_SWITCH && !t_active && $stable(s_reg.src))
    |=> port_level == !$past(s_reg.pol[POLARITY_BIT]))
    else $error("wrong idle level of pulse output");

  a_led_dark: assert property (@(posedge clk) disable iff (!arst_n)
    !t_active |=> !pulse_led)
    else $error("indicator lit without a pulse");

  a_led_with_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    (t_active && s_reg.src != SRC_SWITCH) |=> pulse_led ##0
    (port_level == $past(s_reg.pol[POLARITY_BIT])))
    else $error("pulse not shown on led and port");

  a_start_weight: assert property (@(posedge clk) disable iff (!arst_n)
    s_reg.start |-> $past(s_reg.acc >= weight) ##1 t_active)
    else $error("pulse without a full weight of energy");

  a_unknown_src: assert property (@(posedge clk) disable iff (!arst_n)
    (energy.valid && s_reg.src != SRC_REAL && s_reg.src != SRC_REACTIVE
     && s_reg.src != SRC_APPARENT && !req.wr && !s_reg.start)
    |=> s_reg.acc == $past(s_reg.acc))
    else $error("energy counted for an unknown source");

  a_bacnet_write: assert property (@(posedge clk) disable iff (!arst_n)
    (req.wr && proto_bacnet && req.addr == OBJ_PULSE_SOURCE)
    |=> s_reg.src == $past(req.wdata))
    else $error("bacnet source object not written");

endmodule

/* File: design/pulse_port_pkg.sv */
// pulse_port_pkg: shared types and constants of the energy pulse output port.
// assumes a single 200 MHz clock; energy steps are counted in 0.00001 units.
package pulse_port_pkg;

  // clock and pulse timing
  localparam int CLK_PERIOD_NS  = 5;
  localparam int PULSE_WIDTH_MS = 100;
  localparam int PULSE_CYCLES   = PULSE_WIDTH_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W          = 25;

  // modbus register offsets
  localparam logic [15:0] OFS_SWITCH_LEVEL   = 16'h1131;
  localparam logic [15:0] OFS_PULSE_SOURCE   = 16'h13f5;
  localparam logic [15:0] OFS_RELAY_POLARITY = 16'h13f6;
  localparam logic [15:0] OFS_DATA_SCALAR    = 16'h11f9;

  // bacnet object identifiers
  localparam logic [15:0] OBJ_SWITCH_LEVEL   = 16'h32dc;
  localparam logic [15:0] OBJ_PULSE_SOURCE   = 16'h332c;
  localparam logic [15:0] OBJ_RELAY_POLARITY = 16'h3336;
  localparam logic [15:0] OBJ_PULSE_SCALAR   = 16'h2efe;

  // pulse source codes
  localparam logic [15:0] SRC_SWITCH   = 16'h0000;
  localparam logic [15:0] SRC_REAL     = 16'habe1;
  localparam logic [15:0] SRC_REACTIVE = 16'habe8;
  localparam logic [15:0] SRC_APPARENT = 16'habeb;

  // reset values and field positions
  localparam logic [15:0] RST_SWITCH_LEVEL   = 16'h0001;
  localparam logic [15:0] RST_PULSE_SOURCE   = 16'h0000;
  localparam logic [15:0] RST_RELAY_POLARITY = 16'h0000;
  localparam logic [15:0] RST_SCALAR         = 16'h0000;
  localparam int          LEVEL_BIT          = 0;
  localparam int          POLARITY_BIT       = 0;

  // register selector decoded from an address
  typedef enum logic [2:0] {
    SEL_NONE, SEL_SWITCH, SEL_SOURCE, SEL_POLARITY, SEL_DSCALAR, SEL_PSCALAR
  } reg_sel_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  // increments of the accumulated system energies
  typedef struct packed {
    logic        valid;
    logic [15:0] active_step;
    logic [15:0] reactive_step;
    logic [15:0] apparent_step;
  } energy_step_t;

  // scalar code to pulse weight in 0.00001 units; 6 and above give 100
  function automatic logic [31:0] scalar_weight(input logic [15:0] sc);
    unique case (sc)
      16'h0000: scalar_weight = 32'h0000_0001;
      16'h0001: scalar_weight = 32'h0000_0064;
      16'h0002: scalar_weight = 32'h0000_03e8;
      16'h0003: scalar_weight = 32'h0000_2710;
      16'h0004: scalar_weight = 32'h0001_86a0;
      16'h0005: scalar_weight = 32'h000f_4240;
      default:  scalar_weight = 32'h0098_9680;
    endcase
  endfunction

endpackage

/* File: design/pulse_timer.sv */
// pulse_timer: fixed-width output pulse followed by an equal quiet gap.
// assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/100ps
module pulse_timer
  import pulse_port_pkg::*;
#(
  parameter logic [CNT_W-1:0] WIDTH = CNT_W'(PULSE_CYCLES)
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic start,
  output logic      idle,
  output logic      active
);

  typedef enum logic [1:0] {T_IDLE, T_HIGH, T_GAP} tstate_t;
  typedef struct packed {
    tstate_t          st;
    logic [CNT_W-1:0] cnt;
  } timer_state_t;

  timer_state_t s_reg;
  timer_state_t s_next;

  // the gap keeps back-to-back pulses apart for a counter on the far side
  always_comb begin
    s_next = s_reg;
    unique case (s_reg.st)
      T_IDLE: begin
        if (start) begin
          s_next.st  = T_HIGH;
          s_next.cnt = WIDTH - CNT_W'(1);
        end
      end
      T_HIGH: begin
        if (s_reg.cnt == '0) begin
          s_next.st  = T_GAP;
          s_next.cnt = WIDTH - CNT_W'(1);
        end else begin
          s_next.cnt = s_reg.cnt - CNT_W'(1);
        end
      end
      T_GAP: begin
        if (s_reg.cnt == '0) s_next.st = T_IDLE;
        else s_next.cnt = s_reg.cnt - CNT_W'(1);
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '{st: T_IDLE, cnt: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign idle   = (s_reg.st == T_IDLE);
  assign active = (s_reg.st == T_HIGH);

  a_width_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (active && s_reg.cnt != '0) |=> active)
    else $error("pulse ended before its width");

endmodule

/* File: tb/pulse_counter_model.sv */
// pulse_counter_model: far-side logger that counts pulses on the port pin.
// assumes the pin and the indicator come from the port on clk; en clears it.
`timescale 1ns/100ps
module pulse_counter_model #(
  parameter int WIDTH = 8
) (
  input  wire logic clk,
  input  wire logic en,
  input  wire logic pol,
  input  wire logic port_level,
  input  wire logic pulse_led,
  output int        count,
  output int        errs
);
  int   run;
  logic act;

  // active level is the polarity bit, idle is its inverse
  assign act = en && (port_level === pol);

  // a pulse is counted at its end; a wrong width or a led off the pin is an error
  always @(posedge clk) begin
    if (!en) begin
      count <= 0;
      errs  <= 0;
      run   <= 0;
    end else begin
      if (pulse_led !== act) errs <= errs + 1;
      if (act) begin
        run <= run + 1;
      end else if (run != 0) begin
        if (run != WIDTH) errs <= errs + 1;
        count <= count + 1;
        run   <= 0;
      end
    end
  end
endmodule

/* File: tb/test_energy_pulse_port.sv */
// test_energy_pulse_port: register and pulse scenarios for the output port.
// assumes a short pulse width parameter so pulse trains stay brief.
`timescale 1ns/100ps
module test_energy_pulse_port
  import pulse_port_pkg::*;
;
  localparam int W = 8;
  logic         clk;
  logic         arst_n;
  logic         proto_bacnet;
  logic         en;
  logic         pol;
  reg_req_t     req;
  energy_step_t energy;
  logic [15:0]  rd_data;
  logic         rd_valid;
  logic         port_level;
  logic         pulse_led;
  int           count;
  int           errs;
  int           fail_count;
  int           num_checks;

  energy_pulse_port #(.PULSE_CNT(W)) dut (.clk(clk), .arst_n(arst_n),
    .proto_bacnet(proto_bacnet), .req(req), .energy(energy), .rd_data(rd_data),
    .rd_valid(rd_valid), .port_level(port_level), .pulse_led(pulse_led));
  pulse_counter_model #(.WIDTH(W)) model (.clk(clk), .en(en), .pol(pol),
    .port_level(port_level), .pulse_led(pulse_led), .count(count), .errs(errs));

  always #2.5 clk = ~clk;

  task automatic summarize();
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      fail_count++;
      $display("ERROR %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  // rd_valid and rd_data stand only in the cycle after the taking edge
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    chk_val({15'h0, rd_valid}, 16'h0001);
    chk_val(rd_data, exp);
  endtask

  task automatic feed(input logic [15:0] a, input logic [15:0] r, input logic [15:0] p);
    @(negedge clk);
    energy = '{1'b1, a, r, p};
    @(negedge clk);
    energy = '0;
  endtask

  // selecting a source clears the accumulator, so each run starts from zero
  task automatic run_src(input logic [15:0] sa, input logic [15:0] code,
                         input logic [15:0] a, input logic [15:0] r,
                         input logic [15:0] p, input int n);
    en = 1'b0;
    wr(sa, code);
    en = 1'b1;
    feed(a, r, p);
    hold((n + 1) * 2 * W + 10);
    chk_cnt(count, n);
    chk_cnt(errs, 0);
  endtask

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    proto_bacnet = 1'b0;
    en = 1'b0;
    pol = 1'b0;
    req = '0;
    energy = '0;
    fail_count = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    chk_val({15'h0, port_level}, 16'h0001);
    chk_val({15'h0, pulse_led}, 16'h0000);
    rd(OFS_SWITCH_LEVEL, RST_SWITCH_LEVEL);
    rd(OFS_PULSE_SOURCE, RST_PULSE_SOURCE);
    rd(OFS_RELAY_POLARITY, RST_RELAY_POLARITY);
    rd(16'h0002, 16'h0000);
    wr(OFS_SWITCH_LEVEL, 16'h0000);
    hold(1);
    chk_val({15'h0, port_level}, 16'h0000);
    wr(OFS_SWITCH_LEVEL, 16'h0001);
    hold(1);
    chk_val({15'h0, port_level}, 16'h0001);
    run_src(OFS_PULSE_SOURCE, SRC_SWITCH, 16'hffff, 16'hffff, 16'hffff, 0);
    wr(OFS_DATA_SCALAR, 16'h0001);
    run_src(OFS_PULSE_SOURCE, SRC_REAL, 16'd250, 16'd100, 16'd100, 2);
    feed(16'd50, 16'd0, 16'd0);
    hold(3 * W);
    chk_cnt(count, 3);
    chk_cnt(errs, 0);
    wr(OFS_SWITCH_LEVEL, 16'h0000);
    hold(4);
    chk_val({15'h0, port_level}, 16'h0001);
    // back to open, so a later switch write is seen as a change on the pin
    wr(OFS_SWITCH_LEVEL, 16'h0001);
    run_src(OFS_PULSE_SOURCE, SRC_REACTIVE, 16'd500, 16'd100, 16'd500, 1);
    run_src(OFS_PULSE_SOURCE, SRC_APPARENT, 16'd500, 16'd500, 16'd100, 1);
    run_src(OFS_PULSE_SOURCE, 16'h1234, 16'd500, 16'd500, 16'd500, 0);
    en = 1'b0;
    wr(OFS_RELAY_POLARITY, 16'h0001);
    pol = 1'b1;
    hold(2);
    chk_val({15'h0, port_level}, 16'h0000);
    run_src(OFS_PULSE_SOURCE, SRC_REAL, 16'd100, 16'd0, 16'd0, 1);
    // scalar 7 weighs 10,000,000 steps: 152 full steps fall just short
    wr(OFS_DATA_SCALAR, 16'h0007);
    run_src(OFS_PULSE_SOURCE, SRC_REAL, 16'd0, 16'd0, 16'd0, 0);
    repeat (152) feed(16'hffff, 16'd0, 16'd0);
    hold(20);
    chk_cnt(count, 0);
    feed(16'hffff, 16'd0, 16'd0);
    hold(3 * W);
    chk_cnt(count, 1);
    chk_cnt(errs, 0);
    en = 1'b0;
    // the remainder would pour out at the unit weight of the other protocol
    wr(OFS_PULSE_SOURCE, SRC_SWITCH);
    proto_bacnet = 1'b1;
    wr(OBJ_RELAY_POLARITY, 16'h0000);
    pol = 1'b0;
    wr(OBJ_PULSE_SCALAR, 16'h0002);
    rd(OBJ_PULSE_SCALAR, 16'h0002);
    wr(OBJ_PULSE_SCALAR, 16'h0000);
    rd(OBJ_PULSE_SCALAR, 16'h0000);
    rd(OFS_DATA_SCALAR, 16'h0000);
    run_src(OBJ_PULSE_SOURCE, SRC_APPARENT, 16'd0, 16'd0, 16'd3, 3);
    rd(OBJ_PULSE_SOURCE, SRC_APPARENT);
    en = 1'b0;
    wr(OBJ_PULSE_SOURCE, SRC_SWITCH);
    wr(OBJ_SWITCH_LEVEL, 16'h0000);
    hold(1);
    chk_val({15'h0, port_level}, 16'h0000);
    rd(OBJ_SWITCH_LEVEL, 16'h0000);
    summarize();
  end

  // the scenarios need under a thousand cycles; this cuts a hang short
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
endmodule
